// ### core/ffm_defines.svh
// Constants for the field fault monitor and chain serializer
// What this block does
// [RL1] Supply and temperature monitors update flags continuously, needing no host request.
// [RL2] Supply below the upper alarm trip level drives the supply warning flag to 0.
// [RL3] The supply warning flag never raises the alarm output.
// [RL4] Supply above the upper alarm clear level returns the warning flag to 1.
// [RL5] Supply below the lower trip level clears the low-alarm flag and raises alarm.
// [RL6] Supply above the lower clear level sets the low-alarm flag and drops alarm.
// [RL7] Die temperature above the alarm level sets the overtemp flag and raises alarm.
// [RL8] Overtemp flag and alarm clear only below alarm level minus hysteresis.
// [RL9] Above shutdown temperature the serializer and field regulator are disabled.
// [RL10] Field supply tied to the 5V logic rail reports both supply flags active.
// [RL11] Serial data from a downstream chained device enters the chain serial input.
// [RL12] An isolated SPI clock copy is driven out for every chained device.
// [RL13] An isolated chip-select copy is driven out for every chained device.
// [RL14] Alarm output is active high for low field supply or overtemperature.
// [RL15] 16-bit frames send eight input states, then CRC and three flags.
// [RL16] Flags are captured into the frame when inputs latch at chip-select fall.
`ifndef FFM_DEFINES_SVH
`define FFM_DEFINES_SVH

`define FFM_IN_WIDTH      8
`define FFM_FRAME_WIDTH   16
`define FFM_CRC_WIDTH     5
`define FFM_CRC_POLY      5'h15
`define FFM_CRC_INIT      5'h00
`define FFM_PAD_BYTE      8'hff

// Bit positions inside the vector of pin inputs that pass the synchroniser
`define FFM_SYNC_WIDTH    20
`define FFM_S_IN_LSB      0
`define FFM_S_MODE        8
`define FFM_S_SCLK        9
`define FFM_S_CS_N        10
`define FFM_S_CHAIN       11
`define FFM_S_UP_TRIP     12
`define FFM_S_UP_CLEAR    13
`define FFM_S_LO_TRIP     14
`define FFM_S_LO_CLEAR    15
`define FFM_S_T_ALARM     16
`define FFM_S_T_HYS_LOW   17
`define FFM_S_THERMAL_SHUTDOWN_LEVEL      18
`define FFM_S_TIED        19
`define FFM_SYNC_RST_VAL  20'h00400

// Flag reset values: supply healthy, no overtemperature
`define FFM_WARN_RST      1'b1
`define FFM_LOW_RST       1'b1
`define FFM_OT_RST        1'b0

`endif

// ### core/ffm_pkg.sv
// Types shared by the field fault monitor modules
package ffm_pkg;

    typedef enum logic {FFM_MODE_16, FFM_MODE_8} ffm_mode_t;

    typedef enum logic [1:0] {FFM_IDLE, FFM_ACTIVE, FFM_HALT} ffm_link_state_t;

    typedef struct packed {
        logic low_alarm;
        logic overtemp;
        logic warning;
    } ffm_flags_t;

endpackage

// ### core/ffm_frame_if.sv
// Carrier between the monitor top and the frame shifter
`timescale 1ns/100ps
interface ffm_frame_if;
    import ffm_pkg::*;
    logic        load;
    logic        shift;
    logic [15:0] word;
    ffm_mode_t   mode;
    logic        chain_bit;
    logic        msb;

    modport ctrl (
        output load,
        output shift,
        output word,
        output mode,
        output chain_bit,
        input  msb
    );
    modport shifter (
        input  load,
        input  shift,
        input  word,
        input  mode,
        input  chain_bit,
        output msb
    );
endinterface

// ### core/ffm_frame_shifter.sv
// Frame shift register: parallel load, MSB out, chain data in at the tail
`timescale 1ns/100ps
`include "ffm_defines.svh"
module ffm_frame_shifter
    import ffm_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    ffm_frame_if.shifter fr
);

    logic [`FFM_FRAME_WIDTH-1:0] shreg_r;
    logic [`FFM_FRAME_WIDTH-1:0] shreg_nxt;

    // In 8-bit mode the tail sits at bit 8 so chained data follows IN1 directly
    always_comb begin
        shreg_nxt = shreg_r;
        if (fr.load) begin
            shreg_nxt = fr.word;
        end else if (fr.shift) begin
            shreg_nxt = {shreg_r[`FFM_FRAME_WIDTH-2:0], fr.chain_bit}; // [RL11]
            if (fr.mode == FFM_MODE_8) begin
                shreg_nxt[`FFM_IN_WIDTH] = fr.chain_bit; // [RL11]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_r <= {`FFM_FRAME_WIDTH{1'b1}};
        end else begin
            shreg_r <= shreg_nxt;
        end
    end

    assign fr.msb = shreg_r[`FFM_FRAME_WIDTH-1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    shift_feed_a: assert property (fr.shift && !fr.load |=> shreg_r[0] == $past(fr.chain_bit)) // [RL11]
        else $error("chain bit not taken into the frame tail");
    load_word_a: assert property (fr.load |=> shreg_r == $past(fr.word)) // [RL16]
        else $error("frame word not loaded");

endmodule

// ### core/ffm_monitor_top.sv
// Field fault monitor, alarm output and chained SPI serializer
`timescale 1ns/100ps
`include "ffm_defines.svh"
module ffm_monitor_top
    import ffm_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RESETN,
    input  wire logic [7:0] FIELD_IN,
    input  wire logic       FRAME_LENGTH_SELECT,
    input  wire logic       SPI_CLK,
    input  wire logic       SPI_CS_N,
    output logic            SPI_DOUT,
    input  wire logic       CHAIN_SERIAL_INPUT,
    output logic            CHAIN_CLOCK_OUTPUT,
    output logic            CHAIN_SELECT_OUTPUT,
    input  wire logic       SUPPLY_BELOW_UPPER_TRIP,
    input  wire logic       SUPPLY_ABOVE_UPPER_CLEAR,
    input  wire logic       SUPPLY_BELOW_LOWER_TRIP,
    input  wire logic       SUPPLY_ABOVE_LOWER_CLEAR,
    input  wire logic       TEMP_ABOVE_ALARM,
    input  wire logic       TEMP_BELOW_ALARM_HYS,
    input  wire logic       TEMP_ABOVE_SHUTDOWN,
    input  wire logic       FIELD_SUPPLY_TIED_LOGIC,
    output logic            ALARM,
    output logic            SUPPLY_LOW_ALARM_FLAG,
    output logic            SUPPLY_WARNING_FLAG,
    output logic            OVERTEMP_FLAG,
    output logic            THERMAL_SHUTDOWN
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [`FFM_SYNC_WIDTH-1:0] pins_raw;
    logic [`FFM_SYNC_WIDTH-1:0] meta_r;
    logic [`FFM_SYNC_WIDTH-1:0] sync_r;
    localparam logic [`FFM_SYNC_WIDTH-1:0] SYNC_RST = `FFM_SYNC_RST_VAL;

    assign pins_raw = {FIELD_SUPPLY_TIED_LOGIC, TEMP_ABOVE_SHUTDOWN, TEMP_BELOW_ALARM_HYS,
                       TEMP_ABOVE_ALARM, SUPPLY_ABOVE_LOWER_CLEAR, SUPPLY_BELOW_LOWER_TRIP,
                       SUPPLY_ABOVE_UPPER_CLEAR, SUPPLY_BELOW_UPPER_TRIP, CHAIN_SERIAL_INPUT,
                       SPI_CS_N, SPI_CLK, FRAME_LENGTH_SELECT, FIELD_IN};

    // Monitor comparators and the SPI link both run off their own timing
    genvar gi;
    generate
        for (gi = 0; gi < `FFM_SYNC_WIDTH; gi++) begin : g_sync
            always_ff @(posedge REF_CLK or negedge RESETN) begin
                if (!RESETN) begin
                    meta_r[gi] <= SYNC_RST[gi];
                    sync_r[gi] <= SYNC_RST[gi];
                end else begin
                    meta_r[gi] <= pins_raw[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    logic [7:0] in_s;
    logic       sclk_s;
    logic       cs_n_s;
    logic       chain_s;
    logic       up_trip_s;
    logic       up_clear_s;
    logic       lo_trip_s;
    logic       lo_clear_s;
    logic       t_alarm_s;
    logic       t_hys_low_s;
    logic       thermal_shutdown_level_s;
    logic       tied_s;
    ffm_mode_t  mode_s;

    assign in_s        = sync_r[`FFM_S_IN_LSB +: `FFM_IN_WIDTH];
    assign sclk_s      = sync_r[`FFM_S_SCLK];
    assign cs_n_s      = sync_r[`FFM_S_CS_N];
    assign chain_s     = sync_r[`FFM_S_CHAIN];
    assign up_trip_s   = sync_r[`FFM_S_UP_TRIP];
    assign up_clear_s  = sync_r[`FFM_S_UP_CLEAR];
    assign lo_trip_s   = sync_r[`FFM_S_LO_TRIP];
    assign lo_clear_s  = sync_r[`FFM_S_LO_CLEAR];
    assign t_alarm_s   = sync_r[`FFM_S_T_ALARM];
    assign t_hys_low_s = sync_r[`FFM_S_T_HYS_LOW];
    assign thermal_shutdown_level_s    = sync_r[`FFM_S_THERMAL_SHUTDOWN_LEVEL];
    assign tied_s      = sync_r[`FFM_S_TIED];
    assign mode_s      = sync_r[`FFM_S_MODE] ? FFM_MODE_8 : FFM_MODE_16;

    ////////////////////////////////////////////////////////////////////////////
    // Diagnostic flags, tracked every cycle

    logic warn_r;
    logic low_r;
    logic overtemp_r;
    logic shdn_r;
    logic alarm_r;

    // Comparator pairs give the hysteresis; a trip level wins over its clear level
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            warn_r <= `FFM_WARN_RST;
        end else if (tied_s || up_trip_s) begin
            warn_r <= 1'b0; // [RL1] [RL2] [RL10]
        end else if (up_clear_s) begin
            warn_r <= 1'b1; // [RL4]
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            low_r <= `FFM_LOW_RST;
        end else if (tied_s || lo_trip_s) begin
            low_r <= 1'b0; // [RL1] [RL5] [RL10]
        end else if (lo_clear_s) begin
            low_r <= 1'b1; // [RL6]
        end
    end

    // Overtemp keeps its meaning even with the supply tied low
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            overtemp_r <= `FFM_OT_RST;
        end else if (t_alarm_s) begin
            overtemp_r <= 1'b1; // [RL1] [RL7]
        end else if (t_hys_low_s) begin
            overtemp_r <= 1'b0; // [RL8]
        end
    end

    // Shutdown releases at the same margin as the overtemp flag
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            shdn_r <= 1'b0;
        end else if (thermal_shutdown_level_s) begin
            shdn_r <= 1'b1; // [RL9]
        end else if (t_hys_low_s) begin
            shdn_r <= 1'b0;
        end
    end

    // The warning flag is left out here: it is an early notice, not a fault
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= !low_r || overtemp_r; // [RL3] [RL5] [RL6] [RL7] [RL8] [RL14]
        end
    end

    assign ALARM                 = alarm_r;
    assign SUPPLY_LOW_ALARM_FLAG = low_r;
    assign SUPPLY_WARNING_FLAG   = warn_r;
    assign OVERTEMP_FLAG         = overtemp_r;
    assign THERMAL_SHUTDOWN      = shdn_r;

    ////////////////////////////////////////////////////////////////////////////
    // Link control and frame build

    logic            sclk_prev_r;
    logic            cs_n_prev_r;
    logic            cs_fall;
    logic            sclk_fall;
    ffm_link_state_t state_r;
    ffm_link_state_t state_nxt;
    ffm_flags_t      flags_now;
    logic [4:0]      crc_now;
    logic [15:0]     word_now;
    logic            dout_r;
    logic            chain_clk_r;
    logic            chain_cs_r;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sclk_prev_r <= 1'b0;
            cs_n_prev_r <= 1'b1;
        end else begin
            sclk_prev_r <= sclk_s;
            cs_n_prev_r <= cs_n_s;
        end
    end

    assign cs_fall   = cs_n_prev_r && !cs_n_s;
    assign sclk_fall = sclk_prev_r && !sclk_s;

    function automatic logic [4:0] crc5(input logic [10:0] data);
        logic [4:0] c;
        logic       fb;
        c = `FFM_CRC_INIT;
        for (int i = 10; i >= 0; i--) begin
            fb = c[4] ^ data[i];
            c  = {c[3:0], 1'b0};
            if (fb) begin
                c = c ^ `FFM_CRC_POLY;
            end
        end
        return c;
    endfunction

    assign flags_now = '{low_alarm: low_r, overtemp: overtemp_r, warning: warn_r};
    assign crc_now   = crc5({in_s, flags_now});

    always_comb begin
        if (mode_s == FFM_MODE_16) begin
            word_now = {in_s, crc_now, flags_now}; // [RL15]
        end else begin
            word_now = {in_s, `FFM_PAD_BYTE};
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FFM_IDLE: begin
                if (shdn_r) begin
                    state_nxt = FFM_HALT;
                end else if (cs_fall) begin
                    state_nxt = FFM_ACTIVE;
                end
            end
            FFM_ACTIVE: begin
                if (shdn_r) begin
                    state_nxt = FFM_HALT; // [RL9]
                end else if (cs_n_s) begin
                    state_nxt = FFM_IDLE;
                end
            end
            FFM_HALT: begin
                if (!shdn_r && cs_n_s) begin
                    state_nxt = FFM_IDLE;
                end
            end
            default: state_nxt = FFM_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= FFM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ffm_frame_if frame ();

    // Inputs and flags are both taken from the same cycle, so the CRC matches
    assign frame.load      = (state_r == FFM_IDLE) && cs_fall && !shdn_r; // [RL16]
    assign frame.shift     = (state_r == FFM_ACTIVE) && sclk_fall && !cs_n_s;
    assign frame.word      = word_now;
    assign frame.mode      = mode_s;
    assign frame.chain_bit = chain_s; // [RL11]

    ffm_frame_shifter i_ffm_frame_shifter (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .fr    (frame.shifter)
    );

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dout_r <= 1'b1;
        end else begin
            // Shutdown mutes the line in its first cycle, before the state has left the frame
            dout_r <= (state_r == FFM_ACTIVE && !shdn_r) ? frame.msb : 1'b1; // [RL9] [RL15]
        end
    end

    // Chained parts see the same clock and select; both idle in shutdown
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            chain_clk_r <= 1'b0;
            chain_cs_r  <= 1'b1;
        end else begin
            chain_clk_r <= shdn_r ? 1'b0 : sclk_s; // [RL9] [RL12]
            chain_cs_r  <= shdn_r ? 1'b1 : cs_n_s; // [RL9] [RL13]
        end
    end

    assign SPI_DOUT            = dout_r;
    assign CHAIN_CLOCK_OUTPUT  = chain_clk_r;
    assign CHAIN_SELECT_OUTPUT = chain_cs_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    warn_drop_a: assert property (up_trip_s |=> !warn_r) // [RL2]
        else $error("warning flag not cleared below upper trip");
    warn_quiet_a: assert property (low_r && !overtemp_r |=> !alarm_r) // [RL3]
        else $error("alarm raised without a fault source");
    warn_return_a: assert property (up_clear_s && !up_trip_s && !tied_s |=> warn_r) // [RL4]
        else $error("warning flag not restored above upper clear");
    low_trip_a: assert property (lo_trip_s |=> !low_r ##1 alarm_r) // [RL5]
        else $error("low supply did not clear flag and raise alarm");
    low_clear_a: assert property (lo_clear_s && !lo_trip_s && !tied_s |=> low_r) // [RL6]
        else $error("low-alarm flag not restored");
    temp_set_a: assert property (t_alarm_s |=> overtemp_r ##1 alarm_r) // [RL7] [RL14]
        else $error("overtemp did not set flag and alarm");
    temp_hold_a: assert property (overtemp_r && !t_hys_low_s |=> overtemp_r) // [RL8]
        else $error("overtemp flag cleared above hysteresis margin");
    shdn_idle_a: assert property (shdn_r |=> dout_r && chain_cs_r && !chain_clk_r) // [RL9]
        else $error("serializer active during thermal shutdown");
    tied_rail_a: assert property (tied_s |=> !warn_r && !low_r ##1 alarm_r) // [RL10]
        else $error("tied supply not reported as undervoltage");
    chain_clk_a: assert property (!shdn_r && $rose(sclk_s) |=> chain_clk_r) // [RL12]
        else $error("chain clock copy missing an edge");
    chain_cs_a: assert property (!shdn_r && $fell(cs_n_s) |=> !chain_cs_r) // [RL13]
        else $error("chain select copy not asserted");
    first_bit_a: assert property (frame.load |-> ##2 SPI_DOUT == $past(in_s[7], 2)) // [RL15]
        else $error("first frame bit is not IN8");
    flag_latch_a: assert property (frame.load && mode_s == FFM_MODE_16
                                   |=> i_ffm_frame_shifter.shreg_r[2:0] == $past(flags_now)) // [RL16]
        else $error("flags not captured at frame start");

    frame16_c: cover property (frame.load && mode_s == FFM_MODE_16 ##[1:100] frame.shift);
    frame8_c: cover property (frame.load && mode_s == FFM_MODE_8);
    shutdown_c: cover property ($rose(shdn_r));
    tied_c: cover property (tied_s && alarm_r);

endmodule

// ### test/ffm_spi_host_model.sv
// SPI host and one downstream chained input device facing the monitor
`timescale 1ns/100ps
module ffm_spi_host_model (
    output logic      sclk,
    output logic      cs_n,
    input  wire logic dout,
    output logic      chain_in,
    input  wire logic chain_clk,
    input  wire logic chain_sel
);
    logic [7:0] down_word;
    logic [7:0] down_sr;
    int         clk_edges;
    int         sel_falls;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        chain_in = 1'b0;
        down_word = 8'h00;
        down_sr = 8'h00;
        clk_edges = 0;
        sel_falls = 0;
    end

    // Mode 0 host: sample at the rise, device shifts at the fall; clock idles low outside frames
    // Frames start 1 ns past a clock edge so the synchroniser never races the pins
    task automatic run_frame(input int n, input logic [7:0] dw, output logic [31:0] got);
        got = 32'h0;
        down_word = dw;
        clk_edges = 0;
        sel_falls = 0;
        #1;
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            got = {got[30:0], dout};
            #40;
            sclk = 1'b0;
            #40;
        end
        cs_n = 1'b1;
        #59;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Downstream device runs only from the isolated copies
    always @(negedge chain_sel) begin
        sel_falls++;
        down_sr = down_word;
        chain_in = down_word[7];
    end

    always @(posedge chain_clk) clk_edges++;

    always @(negedge chain_clk) begin
        if (!chain_sel) begin
            #2;
            down_sr = {down_sr[6:0], ~down_sr[0]};
            chain_in = down_sr[7];
        end
    end

    // A released line shows the inverse of its last level, never a stale bit
    always @(posedge chain_sel) chain_in = ~chain_in;
endmodule

// ### test/ffm_monitor_top_tb.sv
// Self-checking bench for the field fault monitor and chain serializer
`timescale 1ns/100ps
module ffm_monitor_top_tb;
    import ffm_pkg::*;

    // Monitor rows: {up_trip, up_clear, lo_trip, lo_clear, t_alarm, t_hys, tied} -> {warn, low, overtemp, alarm}
    typedef struct packed {
        logic [6:0] mon;
        logic [3:0] exp;
    } ffm_row_t;

    localparam ffm_row_t ROWS [13] = '{
        '{7'h00, 4'hc}, '{7'h40, 4'h4}, '{7'h60, 4'h4}, '{7'h20, 4'hc}, '{7'h10, 4'h9},
        '{7'h00, 4'h9}, '{7'h08, 4'hc}, '{7'h04, 4'hf}, '{7'h00, 4'hf}, '{7'h02, 4'hc},
        '{7'h01, 4'h1}, '{7'h05, 4'h3}, '{7'h2a, 4'hc}
    };

    logic        REF_CLK;
    logic        RESETN;
    logic [7:0]  FIELD_IN;
    logic        FRAME_LENGTH_SELECT;
    logic        SPI_CLK;
    logic        SPI_CS_N;
    logic        SPI_DOUT;
    logic        CHAIN_SERIAL_INPUT;
    logic        CHAIN_CLOCK_OUTPUT;
    logic        CHAIN_SELECT_OUTPUT;
    logic [6:0]  mon;
    logic        TEMP_ABOVE_SHUTDOWN;
    logic        ALARM;
    logic        SUPPLY_LOW_ALARM_FLAG;
    logic        SUPPLY_WARNING_FLAG;
    logic        OVERTEMP_FLAG;
    logic        THERMAL_SHUTDOWN;
    logic [31:0] got;
    int          bad_count;
    int          tests_run;

    ffm_monitor_top i_ffm_monitor_top (
        .REF_CLK                  (REF_CLK),
        .RESETN                   (RESETN),
        .FIELD_IN                 (FIELD_IN),
        .FRAME_LENGTH_SELECT      (FRAME_LENGTH_SELECT),
        .SPI_CLK                  (SPI_CLK),
        .SPI_CS_N                 (SPI_CS_N),
        .SPI_DOUT                 (SPI_DOUT),
        .CHAIN_SERIAL_INPUT       (CHAIN_SERIAL_INPUT),
        .CHAIN_CLOCK_OUTPUT       (CHAIN_CLOCK_OUTPUT),
        .CHAIN_SELECT_OUTPUT      (CHAIN_SELECT_OUTPUT),
        .SUPPLY_BELOW_UPPER_TRIP  (mon[6]),
        .SUPPLY_ABOVE_UPPER_CLEAR (mon[5]),
        .SUPPLY_BELOW_LOWER_TRIP  (mon[4]),
        .SUPPLY_ABOVE_LOWER_CLEAR (mon[3]),
        .TEMP_ABOVE_ALARM         (mon[2]),
        .TEMP_BELOW_ALARM_HYS     (mon[1]),
        .TEMP_ABOVE_SHUTDOWN      (TEMP_ABOVE_SHUTDOWN),
        .FIELD_SUPPLY_TIED_LOGIC  (mon[0]),
        .ALARM                    (ALARM),
        .SUPPLY_LOW_ALARM_FLAG    (SUPPLY_LOW_ALARM_FLAG),
        .SUPPLY_WARNING_FLAG      (SUPPLY_WARNING_FLAG),
        .OVERTEMP_FLAG            (OVERTEMP_FLAG),
        .THERMAL_SHUTDOWN         (THERMAL_SHUTDOWN)
    );

    ffm_spi_host_model i_ffm_spi_host_model (
        .sclk      (SPI_CLK),
        .cs_n      (SPI_CS_N),
        .dout      (SPI_DOUT),
        .chain_in  (CHAIN_SERIAL_INPUT),
        .chain_clk (CHAIN_CLOCK_OUTPUT),
        .chain_sel (CHAIN_SELECT_OUTPUT)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Own CRC so the expectation never shares logic with the serializer
    function automatic logic [4:0] crc5(input logic [10:0] d);
        logic [4:0] c;
        logic       fb;
        c = 5'h00;
        for (int i = 10; i >= 0; i--) begin
            fb = c[4] ^ d[i];
            c = {c[3:0], 1'b0};
            if (fb) c = c ^ 5'h15;
        end
        return c;
    endfunction

    function automatic logic [15:0] exp16(input logic [7:0] ins, input logic low, input logic hot, input logic warn);
        return {ins, crc5({ins, low, hot, warn}), low, hot, warn};
    endfunction

    // Three edges to the flags, four to the alarm; six leaves margin
    task automatic set_mon(input logic [6:0] m);
        @(posedge REF_CLK);
        mon <= m;
        repeat (6) @(posedge REF_CLK);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end

    initial begin
        #200000;
        bad_count++;
        $display("[FAIL] %0t run did not finish", $time);
        print_verdict();
    end

    initial begin
        RESETN = 1'b0;
        FIELD_IN = 8'h00;
        FRAME_LENGTH_SELECT = 1'b0;
        mon = 7'h00;
        TEMP_ABOVE_SHUTDOWN = 1'b0;
        bad_count = 0;
        tests_run = 0;
        repeat (8) @(posedge REF_CLK);
        #1;
        check({SPI_DOUT, CHAIN_CLOCK_OUTPUT, CHAIN_SELECT_OUTPUT, ALARM, SUPPLY_WARNING_FLAG,
               SUPPLY_LOW_ALARM_FLAG, OVERTEMP_FLAG, THERMAL_SHUTDOWN}, 8'hac);
        @(posedge REF_CLK);
        RESETN <= 1'b1;
        // Flags move with comparator levels alone, no frame in flight
        foreach (ROWS[i]) begin
            set_mon(ROWS[i].mon);
            check({SUPPLY_WARNING_FLAG, SUPPLY_LOW_ALARM_FLAG, OVERTEMP_FLAG, ALARM}, ROWS[i].exp);
        end
        @(posedge REF_CLK);
        FIELD_IN <= 8'ha5;
        repeat (4) @(posedge REF_CLK);
        i_ffm_spi_host_model.run_frame(24, 8'h3c, got);
        check(got[23:0], {exp16(8'ha5, 1'b1, 1'b0, 1'b1), 8'h3c});
        check(i_ffm_spi_host_model.clk_edges, 24);
        check(i_ffm_spi_host_model.sel_falls, 1);
        check(SPI_DOUT, 1'b1);
        // Back to back in one short frame: chain data follows the last input bit
        FRAME_LENGTH_SELECT <= 1'b1;
        FIELD_IN <= 8'h5a;
        repeat (4) @(posedge REF_CLK);
        i_ffm_spi_host_model.run_frame(16, 8'hc3, got);
        check(got[15:0], {8'h5a, 8'hc3});
        FRAME_LENGTH_SELECT <= 1'b0;
        FIELD_IN <= 8'h0f;
        repeat (4) @(posedge REF_CLK);
        // Inputs and flags that change mid-frame must not leak into it
        fork
            i_ffm_spi_host_model.run_frame(16, 8'h00, got);
            begin
                #200;
                @(posedge REF_CLK);
                mon <= 7'h10;
                FIELD_IN <= 8'hf0;
            end
        join
        check(got[15:0], exp16(8'h0f, 1'b1, 1'b0, 1'b1));
        i_ffm_spi_host_model.run_frame(16, 8'h00, got);
        check(got[15:0], exp16(8'hf0, 1'b0, 1'b0, 1'b1));
        check(ALARM, 1'b1);
        set_mon(7'h0c);
        @(posedge REF_CLK);
        TEMP_ABOVE_SHUTDOWN <= 1'b1;
        for (int i = 0; i < 20 && THERMAL_SHUTDOWN !== 1'b1; i++) @(posedge REF_CLK);
        if (THERMAL_SHUTDOWN !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t thermal shutdown never entered", $time);
            print_verdict();
        end
        i_ffm_spi_host_model.run_frame(16, 8'h00, got);
        check(got[15:0], 16'hffff);
        check(i_ffm_spi_host_model.clk_edges, 0);
        check(i_ffm_spi_host_model.sel_falls, 0);
        check({OVERTEMP_FLAG, ALARM}, 2'h3);
        // Second reset in mid-run with alarms and shutdown still pending
        @(posedge REF_CLK);
        RESETN <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        #1;
        check({SPI_DOUT, CHAIN_CLOCK_OUTPUT, CHAIN_SELECT_OUTPUT, ALARM, SUPPLY_WARNING_FLAG,
               SUPPLY_LOW_ALARM_FLAG, OVERTEMP_FLAG, THERMAL_SHUTDOWN}, 8'hac);
        // Release with the hot-die levels still applied: quiet for two edges, then alarm again
        @(posedge REF_CLK);
        RESETN <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        #1;
        check({SPI_DOUT, CHAIN_CLOCK_OUTPUT, CHAIN_SELECT_OUTPUT, ALARM, SUPPLY_WARNING_FLAG,
               SUPPLY_LOW_ALARM_FLAG, OVERTEMP_FLAG, THERMAL_SHUTDOWN}, 8'hac);
        repeat (3) @(posedge REF_CLK);
        #1;
        check({OVERTEMP_FLAG, ALARM, THERMAL_SHUTDOWN}, 3'h7);
        print_verdict();
    end
endmodule
